// *** design/auto_mute_dither_regs.sv ***
// auto mute policy, analog mute delay and primary dither register block
//
// The AXI4-Lite register port was left to the implementer.
`include "auto_mute_dither_defines.svh"
`default_nettype none
// Summary of operation
// - combine bit joins both channel mutes
// - mute only after zero time elapsed
// - bit one enables right auto mute
// - combined, right disabled keeps left unmuted
// - bit zero enables left auto mute
// - combined, left disabled keeps right unmuted
// - analog mute waits programmed frame periods
// - left ac gain code selects dither
// - right ac gain code selects dither
// - left dem gain only codes 00/01
// - right dem gain only codes 00/01
// - dc dither added to left modulator
// - zero code adds nothing, lsb tiny
// - eleven bit code spans two registers
module auto_mute_dither_regs #(
	parameter int MOD_W = 24,
	parameter int DITHER_SHIFT = 7
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// axi4-lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [`REG_ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	// axi4-lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [`REG_DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	// axi4-lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// axi4-lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [`REG_ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	// axi4-lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [`REG_DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	// zero detection and mute sequencing
	input wire logic left_zero_timeout,
	input wire logic right_zero_timeout,
	input wire logic mute_done,
	input wire logic frame_tick,
	input wire logic unmute_req,
	// mute outputs
	output logic left_automute,
	output logic right_automute,
	output logic analog_mute,
	// primary modulator dither settings
	output logic [1:0] left_pri_ac_gain,
	output logic [1:0] right_pri_ac_gain,
	output logic [1:0] left_pri_dem_gain,
	output logic [1:0] right_pri_dem_gain,
	output logic [`DC_DITHER_W-1:0] left_pri_dc_offset,
	// left primary modulator data path
	input wire logic signed [MOD_W-1:0] left_mod_in,
	output logic signed [MOD_W-1:0] left_mod_out
);
	// register storage
	auto_mute_dither_pkg::mute_policy_t policy_q; // auto mute policy
	logic [7:0] mute_delay_q; // analog mute delay in frame periods
	auto_mute_dither_pkg::dither_gains_t gains_q; // primary dither gains
	logic [7:0] dc_high_q; // dc dither bits 10..8 plus reserved
	logic [7:0] dc_low_q; // dc dither bits 7..0

	// write channel holding
	logic aw_got_q; // address taken, waiting for data
	logic w_got_q; // data taken, waiting for address
	logic [`REG_ADDR_W-1:0] waddr_q; // held write address
	logic [`REG_DATA_W-1:0] wdata_q; // held write data
	logic wlane0_q; // low byte lane enabled
	logic do_write; // both halves present
	logic [7:0] wr_byte; // byte being written
	logic [1:0] wr_resp; // answer for this write

	// read path
	logic [7:0] rd_byte; // selected register value
	logic rd_hit; // read address maps a register

	// address decode: word index in bits 9..2, upper bits must be zero
	function automatic logic is_reg(input logic [`REG_ADDR_W-1:0] addr, input logic [7:0] idx);
		is_reg = (addr[`REG_ADDR_W-1:10] == '0) && (addr[9:2] == idx);
	endfunction : is_reg

	// a mapped address is any of the five register words
	function automatic logic is_mapped(input logic [`REG_ADDR_W-1:0] addr);
		is_mapped = is_reg(addr, `IDX_AUTO_MUTE_POLICY) || is_reg(addr, `IDX_ANALOG_MUTE_DELAY)
			|| is_reg(addr, `IDX_PRIMARY_DITHER_GAINS) || is_reg(addr, `IDX_LEFT_DC_DITHER_HIGH)
			|| is_reg(addr, `IDX_LEFT_DC_DITHER_LOW);
	endfunction : is_mapped

	// response is issued once address and data have both arrived
	assign do_write = aw_got_q & w_got_q & ~bvalid;
	assign wr_byte = wdata_q[7:0];
	assign wr_resp = is_mapped(waddr_q) ? `RESP_OKAY : `RESP_DECERR;

	// write address channel, taken once per write
	always_ff @(posedge core_clk) begin
		if (reset) begin
			awready <= 1'b1;
			aw_got_q <= 1'b0;
			waddr_q <= '0;
		end else if (awvalid && awready) begin
			awready <= 1'b0;
			aw_got_q <= 1'b1;
			waddr_q <= awaddr;
		end else if (do_write) begin
			aw_got_q <= 1'b0;
		end else if (bvalid && bready) begin
			awready <= 1'b1;
		end
	end

	// write data channel, independent of the address
	always_ff @(posedge core_clk) begin
		if (reset) begin
			wready <= 1'b1;
			w_got_q <= 1'b0;
			wdata_q <= '0;
			wlane0_q <= 1'b0;
		end else if (wvalid && wready) begin
			wready <= 1'b0;
			w_got_q <= 1'b1;
			wdata_q <= wdata;
			wlane0_q <= wstrb[0];
		end else if (do_write) begin
			w_got_q <= 1'b0;
		end else if (bvalid && bready) begin
			wready <= 1'b1;
		end
	end

	// write response, one per write
	always_ff @(posedge core_clk) begin
		if (reset) begin
			bvalid <= 1'b0;
			bresp <= `RESP_OKAY;
		end else if (do_write) begin
			bvalid <= 1'b1;
			bresp <= wr_resp;
		end else if (bvalid && bready) begin
			bvalid <= 1'b0;
		end
	end

	// policy and delay registers; upper lanes carry nothing
	always_ff @(posedge core_clk) begin
		if (reset) begin
			policy_q <= `RST_AUTO_MUTE_POLICY;
			mute_delay_q <= `RST_ANALOG_MUTE_DELAY;
		end else if (do_write && wlane0_q) begin
			if (is_reg(waddr_q, `IDX_AUTO_MUTE_POLICY)) begin
				policy_q <= wr_byte;
			end
			if (is_reg(waddr_q, `IDX_ANALOG_MUTE_DELAY)) begin
				mute_delay_q <= wr_byte;
			end
		end
	end

	// gain register; ac fields stored as written
	always_ff @(posedge core_clk) begin
		if (reset) begin
			gains_q <= `RST_PRIMARY_DITHER_GAINS;
		end else if (do_write && wlane0_q && is_reg(waddr_q, `IDX_PRIMARY_DITHER_GAINS)) begin
			gains_q.left_ac <= wr_byte[`GAIN_LEFT_AC_LSB +: 2];
			gains_q.right_ac <= wr_byte[`GAIN_RIGHT_AC_LSB +: 2];
			// reserved dem codes leave the old gain
			if (!wr_byte[`GAIN_LEFT_DEM_LSB + 1]) begin
				gains_q.left_dem <= wr_byte[`GAIN_LEFT_DEM_LSB +: 2];
			end
			if (!wr_byte[`GAIN_RIGHT_DEM_LSB + 1]) begin
				gains_q.right_dem <= wr_byte[`GAIN_RIGHT_DEM_LSB +: 2];
			end
		end
	end

	// dc dither registers; reserved high bits kept as written
	always_ff @(posedge core_clk) begin
		if (reset) begin
			dc_high_q <= `RST_LEFT_DC_DITHER_HIGH;
			dc_low_q <= `RST_LEFT_DC_DITHER_LOW;
		end else if (do_write && wlane0_q) begin
			if (is_reg(waddr_q, `IDX_LEFT_DC_DITHER_HIGH)) begin
				dc_high_q <= wr_byte;
			end
			if (is_reg(waddr_q, `IDX_LEFT_DC_DITHER_LOW)) begin
				dc_low_q <= wr_byte;
			end
		end
	end

	// read mux, unmapped words read zero
	always_comb begin
		rd_hit = is_mapped(araddr);
		rd_byte = 8'h00;
		if (is_reg(araddr, `IDX_AUTO_MUTE_POLICY)) begin
			rd_byte = policy_q;
		end else if (is_reg(araddr, `IDX_ANALOG_MUTE_DELAY)) begin
			rd_byte = mute_delay_q;
		end else if (is_reg(araddr, `IDX_PRIMARY_DITHER_GAINS)) begin
			rd_byte = gains_q;
		end else if (is_reg(araddr, `IDX_LEFT_DC_DITHER_HIGH)) begin
			rd_byte = dc_high_q;
		end else if (is_reg(araddr, `IDX_LEFT_DC_DITHER_LOW)) begin
			rd_byte = dc_low_q;
		end
	end

	// read channel: one outstanding read, data registered
	always_ff @(posedge core_clk) begin
		if (reset) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= `RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= {24'h00_0000, rd_byte};
			rresp <= rd_hit ? `RESP_OKAY : `RESP_DECERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	// auto mute decision, registered so outputs come from flops
	always_ff @(posedge core_clk) begin
		if (reset) begin
			left_automute <= 1'b0;
			right_automute <= 1'b0;
		end else if (policy_q.combine) begin
			// both or neither; one disable blocks both
			left_automute <= policy_q.left_en & policy_q.right_en & left_zero_timeout & right_zero_timeout;
			right_automute <= policy_q.left_en & policy_q.right_en & left_zero_timeout & right_zero_timeout;
		end else begin
			left_automute <= policy_q.left_en & left_zero_timeout;
			right_automute <= policy_q.right_en & right_zero_timeout;
		end
	end

	// setting outputs straight from the register flops
	assign left_pri_ac_gain = gains_q.left_ac;
	assign right_pri_ac_gain = gains_q.right_ac;
	assign left_pri_dem_gain = gains_q.left_dem;
	assign right_pri_dem_gain = gains_q.right_dem;

	assign left_pri_dc_offset = {dc_high_q[`DC_DITHER_HIGH_W-1:0], dc_low_q};

	mute_delay_timer #(
		.DLY_W(8)
	) u_delay (
		.core_clk(core_clk),
		.reset(reset),
		.mute_done(mute_done),
		.frame_tick(frame_tick),
		.unmute_req(unmute_req),
		.delay(mute_delay_q),
		.analog_mute(analog_mute)
	);

	// dither into the left primary modulator
	dc_dither_adder #(
		.MOD_W(MOD_W),
		.DITH_W(`DC_DITHER_W),
		.SHIFT(DITHER_SHIFT)
	) u_left_dc (
		.core_clk(core_clk),
		.reset(reset),
		.mod_in(left_mod_in),
		.dither(left_pri_dc_offset),
		.mod_out(left_mod_out)
	);

	// policy and register checks: mute outputs lag their inputs by one flop
	AST_INDEP_LEFT: assert property (@(posedge core_clk) disable iff (reset)
		(!policy_q.combine && policy_q.left_en && left_zero_timeout) |=> left_automute)
		else $error("independent left auto mute missing");
	AST_COMBINED_PAIR: assert property (@(posedge core_clk) disable iff (reset)
		policy_q.combine |=> left_automute == right_automute)
		else $error("combined mode muted one channel alone");
	AST_ZERO_GATE: assert property (@(posedge core_clk) disable iff (reset)
		!left_zero_timeout || !right_zero_timeout |=> !(left_automute && right_automute)
		|| $past(policy_q.combine) == 1'b0)
		else $error("combined mute before both zero timers ran");
	AST_RIGHT_EN: assert property (@(posedge core_clk) disable iff (reset)
		!policy_q.right_en |=> !right_automute)
		else $error("right auto mute while disabled");
	AST_RIGHT_OFF_LEFT: assert property (@(posedge core_clk) disable iff (reset)
		(policy_q.combine && !policy_q.right_en) |=> !left_automute)
		else $error("left muted with right disabled in combined mode");
	AST_LEFT_EN: assert property (@(posedge core_clk) disable iff (reset)
		!policy_q.left_en |=> !left_automute)
		else $error("left auto mute while disabled");
	AST_LEFT_OFF_RIGHT: assert property (@(posedge core_clk) disable iff (reset)
		(policy_q.combine && !policy_q.left_en) |=> !right_automute)
		else $error("right muted with left disabled in combined mode");
	AST_AC_GAIN_WRITE: assert property (@(posedge core_clk) disable iff (reset)
		(do_write && wlane0_q && is_reg(waddr_q, `IDX_PRIMARY_DITHER_GAINS))
		|=> left_pri_ac_gain == $past(wr_byte[7:6]) && right_pri_ac_gain == $past(wr_byte[5:4]))
		else $error("ac gain not taken from the write");
	AST_DEM_LEGAL: assert property (@(posedge core_clk) disable iff (reset)
		!left_pri_dem_gain[1] && !right_pri_dem_gain[1])
		else $error("reserved dem gain code stored");
	AST_DC_CODE: assert property (@(posedge core_clk) disable iff (reset)
		(do_write && wlane0_q && is_reg(waddr_q, `IDX_LEFT_DC_DITHER_LOW))
		|=> left_pri_dc_offset[7:0] == $past(wr_byte))
		else $error("low dither byte not in the code");
	AST_DC_HIGH: assert property (@(posedge core_clk) disable iff (reset)
		(do_write && wlane0_q && is_reg(waddr_q, `IDX_LEFT_DC_DITHER_HIGH))
		|=> left_pri_dc_offset[10:8] == $past(wr_byte[2:0]))
		else $error("high dither bits not in the code");
	AST_INDEP_RIGHT: assert property (@(posedge core_clk) disable iff (reset)
		(!policy_q.combine && policy_q.right_en && right_zero_timeout) |=> right_automute)
		else $error("independent right auto mute missing");
	AST_DEM_KEEP: assert property (@(posedge core_clk) disable iff (reset)
		(do_write && wlane0_q && is_reg(waddr_q, `IDX_PRIMARY_DITHER_GAINS) && wr_byte[1])
		|=> $stable(right_pri_dem_gain))
		else $error("reserved right dem code changed the gain");

	// main scenarios worth seeing reached
	COV_COMBINED_MUTE: cover property (@(posedge core_clk) disable iff (reset)
		policy_q.combine && left_automute && right_automute);
	COV_INDEP_LEFT_ONLY: cover property (@(posedge core_clk) disable iff (reset)
		!policy_q.combine && left_automute && !right_automute);
	COV_DEM_REFUSED: cover property (@(posedge core_clk) disable iff (reset)
		do_write && is_reg(waddr_q, `IDX_PRIMARY_DITHER_GAINS) && wr_byte[3]);
endmodule : auto_mute_dither_regs
`default_nettype wire

// *** pkg/auto_mute_dither_defines.svh ***
// register indices, byte addresses, field positions and reset values
`ifndef AUTO_MUTE_DITHER_DEFINES_SVH
`define AUTO_MUTE_DITHER_DEFINES_SVH
// printed register indices; byte address is four times the index
`define IDX_AUTO_MUTE_POLICY 8'h41
`define IDX_ANALOG_MUTE_DELAY 8'h42
`define IDX_PRIMARY_DITHER_GAINS 8'h43
`define IDX_LEFT_DC_DITHER_HIGH 8'h44
`define IDX_LEFT_DC_DITHER_LOW 8'h45
// bus geometry
`define REG_ADDR_W 12
`define REG_DATA_W 32
// auto mute policy fields
`define POL_LEFT_EN_BIT 0
`define POL_RIGHT_EN_BIT 1
`define POL_COMBINE_BIT 2
// primary dither gain fields (lsb positions, 2 bits each)
`define GAIN_RIGHT_DEM_LSB 0
`define GAIN_LEFT_DEM_LSB 2
`define GAIN_RIGHT_AC_LSB 4
`define GAIN_LEFT_AC_LSB 6
// reset values
`define RST_AUTO_MUTE_POLICY 8'h07
`define RST_ANALOG_MUTE_DELAY 8'h0c
`define RST_PRIMARY_DITHER_GAINS 8'h00
`define RST_LEFT_DC_DITHER_HIGH 8'h00
`define RST_LEFT_DC_DITHER_LOW 8'h00
// dc dither geometry: 3 high bits plus 8 low bits
`define DC_DITHER_W 11
`define DC_DITHER_HIGH_W 3
// axi responses
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
`endif

// *** pkg/auto_mute_dither_pkg.sv ***
// types shared by the auto mute and dither register block
`default_nettype none
package auto_mute_dither_pkg;
	// analog mute delay sequencer states, gray along idle-count-muted
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_COUNT = 2'h1,
		ST_MUTED = 2'h3
	} analog_mute_state_t;
	// auto mute policy bits as stored
	typedef struct packed {
		logic [4:0] reserved;
		logic combine;
		logic right_en;
		logic left_en;
	} mute_policy_t;
	// primary dither gain fields as stored
	typedef struct packed {
		logic [1:0] left_ac;
		logic [1:0] right_ac;
		logic [1:0] left_dem;
		logic [1:0] right_dem;
	} dither_gains_t;
endpackage : auto_mute_dither_pkg
`default_nettype wire

// *** design/mute_delay_timer.sv ***
// analog mute delay sequencer counting frame periods
`default_nettype none
module mute_delay_timer #(
	parameter int DLY_W = 8
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// mute sequencing
	input wire logic mute_done,
	input wire logic frame_tick,
	input wire logic unmute_req,
	input wire logic [DLY_W-1:0] delay,
	// result
	output logic analog_mute
);
	auto_mute_dither_pkg::analog_mute_state_t state_q, state_d; // sequencer state
	logic [DLY_W-1:0] cnt_q; // frame periods left
	logic done_q; // previous digital mute level
	logic start; // digital mute just completed

	// only a fresh completion starts a count, so a held level after unmute does not re-arm
	assign start = mute_done & ~done_q & ~unmute_req;

	// next state
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			auto_mute_dither_pkg::ST_IDLE: begin
				if (start) begin
					state_d = (delay == '0) ? auto_mute_dither_pkg::ST_MUTED : auto_mute_dither_pkg::ST_COUNT;
				end
			end
			auto_mute_dither_pkg::ST_COUNT: begin
				if (unmute_req) begin
					state_d = auto_mute_dither_pkg::ST_IDLE;
				end else if (frame_tick && cnt_q == DLY_W'(1)) begin
					state_d = auto_mute_dither_pkg::ST_MUTED;
				end
			end
			auto_mute_dither_pkg::ST_MUTED: begin
				if (unmute_req) begin
					state_d = auto_mute_dither_pkg::ST_IDLE;
				end
			end
			default: begin
				state_d = auto_mute_dither_pkg::ST_IDLE;
			end
		endcase
	end

	// state and edge register
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_q <= auto_mute_dither_pkg::ST_IDLE;
			done_q <= 1'b0;
		end else begin
			state_q <= state_d;
			done_q <= mute_done;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			cnt_q <= '0;
		end else if (state_q == auto_mute_dither_pkg::ST_IDLE && start) begin
			cnt_q <= delay;
		end else if (state_q == auto_mute_dither_pkg::ST_COUNT && frame_tick) begin
			cnt_q <= cnt_q - DLY_W'(1);
		end
	end

	// output flop follows next state
	always_ff @(posedge core_clk) begin
		if (reset) begin
			analog_mute <= 1'b0;
		end else begin
			analog_mute <= (state_d == auto_mute_dither_pkg::ST_MUTED);
		end
	end

	AST_DELAY_ZERO: assert property (@(posedge core_clk) disable iff (reset)
		(state_q == auto_mute_dither_pkg::ST_IDLE && start && delay == '0) |=> analog_mute)
		else $error("zero delay did not mute at once");
	AST_DELAY_LAST_TICK: assert property (@(posedge core_clk) disable iff (reset)
		$rose(analog_mute) |-> ($past(state_q) == auto_mute_dither_pkg::ST_IDLE && $past(delay) == '0)
		|| ($past(cnt_q) == DLY_W'(1) && $past(frame_tick)))
		else $error("analog mute rose before the delay ran out");
	AST_UNMUTE_ABORT: assert property (@(posedge core_clk) disable iff (reset)
		unmute_req |=> !analog_mute)
		else $error("analog mute held across unmute");
	COV_DELAYED_MUTE: cover property (@(posedge core_clk) disable iff (reset)
		state_q == auto_mute_dither_pkg::ST_COUNT ##1 $rose(analog_mute));
	COV_ABORT: cover property (@(posedge core_clk) disable iff (reset)
		state_q == auto_mute_dither_pkg::ST_COUNT && unmute_req);
endmodule : mute_delay_timer
`default_nettype wire

// *** design/dc_dither_adder.sv ***
// saturating dc dither injection into a modulator input
`default_nettype none
module dc_dither_adder #(
	parameter int MOD_W = 24,
	parameter int DITH_W = 11,
	parameter int SHIFT = 7
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// data path
	input wire logic signed [MOD_W-1:0] mod_in,
	input wire logic [DITH_W-1:0] dither,
	output logic signed [MOD_W-1:0] mod_out
);
	logic [MOD_W:0] ext; // dither aligned to modulator lsb
	logic signed [MOD_W:0] sum; // one guard bit

	// zero code adds nothing
	// dither lsb is 2^-11 of 1/32 full scale, SHIFT places it on the modulator grid
	assign ext = (MOD_W + 1)'({{(MOD_W + 1 - DITH_W){1'b0}}, dither} << SHIFT);
	assign sum = $signed({mod_in[MOD_W-1], mod_in}) + $signed(ext);

	// add dither, clamp at positive full scale
	always_ff @(posedge core_clk) begin
		if (reset) begin
			mod_out <= '0;
		end else if (sum[MOD_W] != sum[MOD_W-1]) begin
			mod_out <= {1'b0, {(MOD_W - 1){1'b1}}};
		end else begin
			mod_out <= sum[MOD_W-1:0];
		end
	end

	AST_NO_DITHER: assert property (@(posedge core_clk) disable iff (reset)
		dither == '0 |=> mod_out == $past(mod_in))
		else $error("zero dither code changed the sample");
	AST_DITHER_ADDS: assert property (@(posedge core_clk) disable iff (reset)
		(dither != '0 && !mod_in[MOD_W-1]) |=> (mod_out > $past(mod_in)
		|| mod_out == {1'b0, {(MOD_W - 1){1'b1}}}))
		else $error("dither did not raise the sample");
endmodule : dc_dither_adder
`default_nettype wire

// *** bench/auto_mute_and_dac_dither_config_bench.sv ***
// self-checking bench for the auto mute and dither register block
`include "auto_mute_dither_defines.svh"
`default_nettype none
module auto_mute_and_dac_dither_config_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MOD_W = 24; // modulator word width
	localparam int SHIFT = 7; // dither alignment handed to the block
	localparam int LIM = 64; // bound on every handshake wait
	// clock, reset and bus signals
	logic core_clk, reset;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	// mute sequencing stimulus and results
	logic lz, rz, mute_done, frame_tick, unmute_req, l_am, r_am, analog_mute;
	logic [1:0] lac, rac, ldem, rdem;
	logic [10:0] dc_off;
	logic signed [MOD_W-1:0] mod_in, mod_out;
	// scoreboard counters
	int error_cnt = 0;
	int checks = 0;
	logic [1:0] resp;
	logic [31:0] rd_v;
	logic [31:0] exp_v;
	logic seen;
	// the design under test
	auto_mute_dither_regs #(.MOD_W(MOD_W), .DITHER_SHIFT(SHIFT)) DUT (
		.core_clk(core_clk), .reset(reset),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'h1),
		.bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.left_zero_timeout(lz), .right_zero_timeout(rz), .mute_done(mute_done),
		.frame_tick(frame_tick), .unmute_req(unmute_req),
		.left_automute(l_am), .right_automute(r_am), .analog_mute(analog_mute),
		.left_pri_ac_gain(lac), .right_pri_ac_gain(rac), .left_pri_dem_gain(ldem),
		.right_pri_dem_gain(rdem), .left_pri_dc_offset(dc_off),
		.left_mod_in(mod_in), .left_mod_out(mod_out));
	// free running 100 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// verdict and end of run, the only exit
	task automatic stop_test();
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	// one comparison of seen against expected
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// a bounded wait ran out, so the run cannot go on
	task automatic hang(input int n);
		if (n >= LIM) begin
			error_cnt++;
			$display("[ERR] %0t handshake wait ran out", $time);
			stop_test();
		end
	endtask : hang
	// byte address of a register index
	function automatic logic [11:0] ba(input logic [7:0] idx);
		return {2'b00, idx, 2'b00};
	endfunction : ba
	// write: address and data offered together, each released once taken
	task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
		int n;
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge core_clk);
		awaddr <= a;
		wdata <= 32'(d);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		for (n = 0; n < LIM && !(aw_ok && w_ok); n++) begin
			@(posedge core_clk);
			if (awvalid && awready === 1'b1) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready === 1'b1) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		hang(n);
		bready <= 1'b1;
		// bready held until the response is sampled
		for (n = 0; n < LIM; n++) begin
			@(posedge core_clk);
			if (bready && bvalid === 1'b1) break;
		end
		hang(n);
		r = bresp;
		bready <= 1'b0;
	endtask : wr
	// read: address held until taken, rready held until data sampled
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < LIM; n++) begin
			@(posedge core_clk);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
			if (rready && rvalid === 1'b1) break;
		end
		hang(n);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd
	// one frame clock pulse lasting a single cycle
	task automatic tick();
		@(posedge core_clk);
		frame_tick <= 1'b1;
		@(posedge core_clk);
		frame_tick <= 1'b0;
	endtask : tick
	// watch analog mute for a few settled cycles
	task automatic watch_am(output logic s);
		s = 1'b0;
		repeat (4) begin
			@(posedge core_clk);
			s = s | (analog_mute === 1'b1);
		end
	endtask : watch_am
	// main sequence
	initial begin
		reset = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		{lz, rz, mute_done, frame_tick, unmute_req} = '0;
		mod_in = 24'h01_0000;
		repeat (16) @(posedge core_clk);
		reset <= 1'b0;
		// reset values of the first four registers and the dither outputs
		for (int i = 0; i < 4; i++) begin
			rd(ba(8'h41 + 8'(i)), rd_v, resp);
			exp_v = (i == 0) ? 32'h0000_0007 : (i == 1) ? 32'h0000_000c : 32'h0000_0000;
			chk(rd_v, exp_v);
		end
		chk({lac, rac, ldem, rdem, 21'(dc_off)}, 32'h0000_0000);
		// unmapped places answer with a decode error
		rd(12'h200, rd_v, resp);
		chk(32'(resp), 32'(`RESP_DECERR));
		wr(12'h200, 8'h5a, resp);
		chk(32'(resp), 32'(`RESP_DECERR));
		// gain codes 00 and 01 reach every field
		wr(ba(`IDX_PRIMARY_DITHER_GAINS), 8'h55, resp);
		repeat (2) @(posedge core_clk);
		chk({lac, rac, ldem, rdem}, 32'h0000_0055);
		wr(ba(`IDX_PRIMARY_DITHER_GAINS), 8'h00, resp);
		repeat (2) @(posedge core_clk);
		chk({lac, rac, ldem, rdem}, 32'h0000_0000);
		// reserved dem codes leave the old field value
		wr(ba(`IDX_PRIMARY_DITHER_GAINS), 8'h5b, resp);
		rd(ba(`IDX_PRIMARY_DITHER_GAINS), rd_v, resp);
		chk(rd_v, 32'h0000_0050);
		// dc dither code split over two registers, added to the modulator input
		wr(ba(`IDX_LEFT_DC_DITHER_HIGH), 8'h05, resp);
		wr(ba(`IDX_LEFT_DC_DITHER_LOW), 8'ha3, resp);
		repeat (3) @(posedge core_clk);
		chk(32'(dc_off), 32'h0000_05a3);
		chk(32'(mod_out), 32'(24'h01_0000 + (24'h00_05a3 << SHIFT)));
		// a sample near full scale clamps instead of wrapping
		mod_in <= 24'h7f_ff00;
		repeat (2) @(posedge core_clk);
		chk(32'(mod_out), 32'h007f_ffff);
		mod_in <= 24'h01_0000;
		wr(ba(`IDX_LEFT_DC_DITHER_HIGH), 8'h00, resp);
		wr(ba(`IDX_LEFT_DC_DITHER_LOW), 8'h00, resp);
		repeat (3) @(posedge core_clk);
		chk(32'(mod_out), 32'(24'h01_0000));
		// every policy against every zero detection pattern
		for (int p = 0; p < 8; p++) begin
			wr(ba(`IDX_AUTO_MUTE_POLICY), 8'(p), resp);
			for (int z = 0; z < 4; z++) begin
				@(posedge core_clk);
				lz <= z[0];
				rz <= z[1];
				repeat (3) @(posedge core_clk);
				if (p[2]) exp_v = {30'h0, {2{p[0] & p[1] & z[0] & z[1]}}};
				else exp_v = {30'h0, p[0] & z[0], p[1] & z[1]};
				chk({30'h0, l_am, r_am}, exp_v);
			end
		end
		// largest delay is stored whole
		wr(ba(`IDX_ANALOG_MUTE_DELAY), 8'hff, resp);
		rd(ba(`IDX_ANALOG_MUTE_DELAY), rd_v, resp);
		chk(rd_v, 32'h0000_00ff);
		// delay of three frames: silent after two, set after the third
		wr(ba(`IDX_ANALOG_MUTE_DELAY), 8'h03, resp);
		@(posedge core_clk);
		mute_done <= 1'b1;
		repeat (2) tick();
		watch_am(seen);
		chk(32'(seen), 32'h0000_0000);
		tick();
		watch_am(seen);
		chk(32'(seen), 32'h0000_0001);
		// unmute releases analog mute
		@(posedge core_clk);
		mute_done <= 1'b0;
		unmute_req <= 1'b1;
		@(posedge core_clk);
		unmute_req <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk(32'(analog_mute), 32'h0000_0000);
		// unmute in mid count abandons it
		mute_done <= 1'b1;
		tick();
		@(posedge core_clk);
		unmute_req <= 1'b1;
		@(posedge core_clk);
		unmute_req <= 1'b0;
		repeat (3) tick();
		watch_am(seen);
		chk(32'(seen), 32'h0000_0000);
		// zero delay mutes right after digital mute completes
		mute_done <= 1'b0;
		wr(ba(`IDX_ANALOG_MUTE_DELAY), 8'h00, resp);
		@(posedge core_clk);
		mute_done <= 1'b1;
		watch_am(seen);
		chk(32'(seen), 32'h0000_0001);
		stop_test();
	end
endmodule : auto_mute_and_dac_dither_config_bench
`default_nettype wire
